// >>> rtl/cold_load_regs.svh
// What this block does
// - Cold load needs all phases idle, then one above start within 80 ms
// - Cold load output ends at maximum time or when current drops below pickup
// - A rise slower than 80 ms from idle to start gives no detection
// - Inrush needs cold load condition plus second harmonic above threshold
// - A zero harmonic threshold makes inrush equal to cold load
// - Blocking starts on rise, kept after one cycle only with harmonic content
// - Idle threshold settable 0.01 to 0.50 times nominal current
// - Start threshold settable 0.30 to 10.00 times nominal current
// - Maximum time settable up to 300.00 s in 0.01 s steps
// - Harmonic ratio threshold settable 0 to 99 percent
`ifndef COLD_LOAD_REGS_SVH
`define COLD_LOAD_REGS_SVH
// ----------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------
// Currents in hundredths of nominal current
`define CL_CUR_W 10
`define CL_IDLE_MIN 10'h001
`define CL_IDLE_MAX 10'h032
`define CL_START_MIN 10'h01E
`define CL_START_MAX 10'h3E8
`define CL_PCT_W 7
`define CL_PCT_MAX 7'h63
`define CL_TIME_W 15
`define CL_TIME_MAX 15'h7530
`define CL_CLK_HZ 100000000
`define CL_WIN_MS 80
`define CL_WIN_CYC (`CL_CLK_HZ / 1000 * `CL_WIN_MS)
`define CL_STEP_CYC (`CL_CLK_HZ / 100)
`define CL_CNT_W 24
`endif

// >>> rtl/cold_load_pkg.sv
`default_nettype none
package cold_load_pkg;
  typedef enum logic [1:0] {ST_WAIT_IDLE, ST_IDLE, ST_ARMED, ST_ACTIVE} cl_state_t;
endpackage
`default_nettype wire

// >>> rtl/cl_clamp.sv
`default_nettype none
`include "cold_load_regs.svh"
// ----------------------------------------------------------------
// Setting clamp to the documented range
// ----------------------------------------------------------------
module cl_clamp #(
  parameter int W = 10,
  parameter logic [W-1:0] LO = '0,
  parameter logic [W-1:0] HI = '1
) (
  input wire logic [W-1:0] i_val,
  output logic [W-1:0] o_val
);
  // Out-of-range settings are pulled to the nearest limit
  assign o_val = (i_val < LO) ? LO : ((i_val > HI) ? HI : i_val);
endmodule
`default_nettype wire

// >>> rtl/cl_timer.sv
`default_nettype none
`include "cold_load_regs.svh"
// ----------------------------------------------------------------
// Prescaled down counter: 0.01 s ticks
// ----------------------------------------------------------------
module cl_timer (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [`CL_TIME_W-1:0] i_steps,
  output logic o_done
);
  logic [`CL_CNT_W-1:0] pre_q;
  logic [`CL_TIME_W-1:0] left_q;
  logic [`CL_CNT_W-1:0] step_last;
  wire tick;
  assign step_last = `CL_CNT_W'(`CL_STEP_CYC - 1);
  assign tick = (pre_q == step_last);
  assign o_done = (left_q == '0) & ~i_load;
  // Reload restarts the prescaler so every step is full length
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pre_q <= '0;
      left_q <= '0;
    end else if (i_load) begin
      pre_q <= '0;
      left_q <= i_steps;
    end else if (left_q != '0) begin
      pre_q <= tick ? '0 : pre_q + `CL_CNT_W'(1);
      if (tick) left_q <= left_q - `CL_TIME_W'(1);
    end
  end
endmodule
`default_nettype wire

// >>> rtl/cold_load_detector.sv
`default_nettype none
`include "cold_load_regs.svh"
// ----------------------------------------------------------------
// Cold load and magnetizing inrush detector
// ----------------------------------------------------------------
module cold_load_detector (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic [`CL_CUR_W-1:0] i_phase_cur_0,
  input wire logic [`CL_CUR_W-1:0] i_phase_cur_1,
  input wire logic [`CL_CUR_W-1:0] i_phase_cur_2,
  input wire logic [`CL_PCT_W-1:0] i_second_harmonic_ratio_0,
  input wire logic [`CL_PCT_W-1:0] i_second_harmonic_ratio_1,
  input wire logic [`CL_PCT_W-1:0] i_second_harmonic_ratio_2,
  input wire logic i_cycle_done,
  input wire logic [`CL_CUR_W-1:0] i_idle_set,
  input wire logic [`CL_CUR_W-1:0] i_start_set,
  input wire logic [`CL_TIME_W-1:0] i_max_time_set,
  input wire logic [`CL_PCT_W-1:0] i_harm_set,
  output logic o_cold_load,
  output logic o_inrush,
  output logic o_inrush_block
);
  cold_load_pkg::cl_state_t state_q, state_d;
  logic [`CL_CUR_W-1:0] idle_lim, start_lim;
  logic [`CL_PCT_W-1:0] harm_lim;
  logic [`CL_TIME_W-1:0] max_steps;
  logic [`CL_CNT_W-1:0] win_q;
  logic [`CL_CNT_W-1:0] win_last;
  logic [2:0] below_idle, above_start, harm_hi;
  logic [`CL_CUR_W-1:0] cur [3];
  logic [`CL_PCT_W-1:0] harm [3];
  logic harm_seen_q, cyc_wait_q;
  logic cold_q, inrush_q, block_q;
  wire all_idle, any_start, any_harm, win_open, start_det, drop, max_done;

  // ----------------------------------------------------------------
  // Setting limits
  // ----------------------------------------------------------------
  cl_clamp #(.W(`CL_CUR_W), .LO(`CL_IDLE_MIN), .HI(`CL_IDLE_MAX)) u_idle (
    .i_val(i_idle_set), .o_val(idle_lim));
  cl_clamp #(.W(`CL_CUR_W), .LO(`CL_START_MIN), .HI(`CL_START_MAX))
    u_start (.i_val(i_start_set), .o_val(start_lim));
  cl_clamp #(.W(`CL_PCT_W), .LO('0), .HI(`CL_PCT_MAX)) u_harm (
    .i_val(i_harm_set), .o_val(harm_lim));
  cl_clamp #(.W(`CL_TIME_W), .LO(`CL_TIME_W'(1)), .HI(`CL_TIME_MAX))
    u_time (.i_val(i_max_time_set), .o_val(max_steps));

  // ----------------------------------------------------------------
  // Per-phase comparisons
  // ----------------------------------------------------------------
  assign cur[0] = i_phase_cur_0;
  assign cur[1] = i_phase_cur_1;
  assign cur[2] = i_phase_cur_2;
  assign harm[0] = i_second_harmonic_ratio_0;
  assign harm[1] = i_second_harmonic_ratio_1;
  assign harm[2] = i_second_harmonic_ratio_2;
  generate
    for (genvar p = 0; p < 3; p++) begin : g_ph
      assign below_idle[p] = cur[p] < idle_lim;
      assign above_start[p] = cur[p] > start_lim;
      // Zero threshold: any ratio passes, inrush follows cold load
      assign harm_hi[p] = (harm_lim == '0) | (harm[p] > harm_lim);
    end
  endgenerate
  assign all_idle = &below_idle;
  assign any_start = |above_start;
  assign any_harm = |harm_hi;
  assign win_last = `CL_CNT_W'(`CL_WIN_CYC - 1);
  assign win_open = win_q < win_last;
  // Rise must come while the 80 ms window is still open
  assign start_det = (state_q == cold_load_pkg::ST_ARMED) & any_start
                     & win_open;
  // Dropout uses the start level as the pickup level
  assign drop = ~any_start;

  // Idle-to-start jump in one sample also counts as a rise
  wire direct_rise = (state_q == cold_load_pkg::ST_IDLE) & any_start;
  wire rise = start_det | direct_rise;

  // Both rise paths load the timer, else an idle timer ends it at once
  cl_timer u_max (
    .i_mclk(I_MCLK),
    .i_rst(I_RST),
    .i_load(rise),
    .i_steps(max_steps),
    .o_done(max_done)
  );

  // ----------------------------------------------------------------
  // Sequence: idle, leave idle, rise within window, active
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      cold_load_pkg::ST_WAIT_IDLE: if (all_idle) begin
        state_d = cold_load_pkg::ST_IDLE;
      end
      cold_load_pkg::ST_IDLE: if (!all_idle) begin
        state_d = any_start ? cold_load_pkg::ST_ACTIVE
                            : cold_load_pkg::ST_ARMED;
      end
      cold_load_pkg::ST_ARMED: begin
        if (all_idle) state_d = cold_load_pkg::ST_IDLE;
        else if (start_det) state_d = cold_load_pkg::ST_ACTIVE;
        else if (!win_open) state_d = cold_load_pkg::ST_WAIT_IDLE;
      end
      cold_load_pkg::ST_ACTIVE: if (max_done || drop) begin
        state_d = cold_load_pkg::ST_WAIT_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State and 80 ms window counter
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= cold_load_pkg::ST_WAIT_IDLE;
      win_q <= '0;
    end else begin
      state_q <= state_d;
      // Window starts when the first phase leaves idle
      if (state_q != cold_load_pkg::ST_ARMED) win_q <= '0;
      else if (win_open) win_q <= win_q + `CL_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Outputs: cold load, inrush and block
  // ----------------------------------------------------------------
  // Activity ends at dropout or when the loaded maximum time runs out
  wire active_end = (state_q == cold_load_pkg::ST_ACTIVE)
                    & (state_d != cold_load_pkg::ST_ACTIVE);
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      cold_q <= 1'b0;
      inrush_q <= 1'b0;
      block_q <= 1'b0;
      cyc_wait_q <= 1'b0;
      harm_seen_q <= 1'b0;
    end else if (rise) begin
      cold_q <= 1'b1;
      inrush_q <= any_harm;
      block_q <= 1'b1;
      cyc_wait_q <= 1'b1;
      harm_seen_q <= 1'b0;
    end else if (active_end) begin
      cold_q <= 1'b0;
      inrush_q <= 1'b0;
      block_q <= 1'b0;
      cyc_wait_q <= 1'b0;
    end else begin
      if (cold_q && any_harm) inrush_q <= 1'b1;
      if (cyc_wait_q && i_cycle_done) begin
        cyc_wait_q <= 1'b0;
        block_q <= any_harm;
        harm_seen_q <= any_harm;
      end
    end
  end
  assign o_cold_load = cold_q;
  assign o_inrush = inrush_q;
  assign o_inrush_block = block_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_late_rise: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (state_q == cold_load_pkg::ST_ARMED && !win_open) |=> !o_cold_load ||
    $past(o_cold_load)) else $error("late rise detected");
  a_rise_sets: assert property (@(posedge I_MCLK) disable iff (I_RST)
    start_det |=> o_cold_load && o_inrush_block)
    else $error("rise not detected");
  a_drop_clears: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (state_q == cold_load_pkg::ST_ACTIVE && drop && !rise) |=> !o_cold_load)
    else $error("dropout ignored");
  a_inrush_sub: assert property (@(posedge I_MCLK) disable iff (I_RST)
    o_inrush |-> o_cold_load) else $error("inrush without cold");
  a_zero_equal: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (harm_lim == '0 && $stable(harm_lim)) |=> o_inrush == o_cold_load ||
    $past(harm_lim) != '0) else $error("zero threshold mismatch");
  a_block_release: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (cyc_wait_q && i_cycle_done && !any_harm && !rise) |=>
    !o_inrush_block) else $error("block not released");
  a_win_bound: assert property (@(posedge I_MCLK) disable iff (I_RST)
    win_q <= win_last) else $error("window overrun");
  a_limits: assert property (@(posedge I_MCLK) disable iff (I_RST)
    idle_lim >= `CL_IDLE_MIN && idle_lim <= `CL_IDLE_MAX &&
    start_lim >= `CL_START_MIN && max_steps <= `CL_TIME_MAX &&
    harm_lim <= `CL_PCT_MAX) else $error("setting out of range");
  c_cold: cover property (@(posedge I_MCLK) disable iff (I_RST)
    $rose(o_cold_load));
  c_inrush: cover property (@(posedge I_MCLK) disable iff (I_RST)
    $rose(o_inrush));
  c_release: cover property (@(posedge I_MCLK) disable iff (I_RST)
    $fell(o_inrush_block) && o_cold_load);
endmodule
`default_nettype wire

// >>> tb/cl_front_end.sv
`default_nettype none
`include "cold_load_regs.svh"
// ----------------------------------------------------------------
// Measurement front end model
// ----------------------------------------------------------------
module cl_front_end #(
  parameter int CYC = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [`CL_CUR_W-1:0] i_cur [3],
  input wire logic [`CL_PCT_W-1:0] i_harm [3],
  output logic [`CL_CUR_W-1:0] o_cur [3],
  output logic [`CL_PCT_W-1:0] o_harm [3],
  output logic o_cycle_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // One pulse per full cycle of harmonic data
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 8'h00;
      o_cycle_done <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == 8'(CYC - 1)) ? 8'h00 : cnt_q + 8'h01;
      o_cycle_done <= (cnt_q == 8'(CYC - 1));
    end
  end
  // Magnitudes lag one sample, as a real filter would
  always_ff @(posedge i_mclk) begin
    o_cur <= i_cur;
    o_harm <= i_harm;
  end
endmodule
`default_nettype wire

// >>> tb/test_cold_load_detector.sv
`default_nettype none
`include "cold_load_regs.svh"
module test_cold_load_detector;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_MCLK = 1'b0;
  logic I_RST = 1'b1;
  logic [`CL_CUR_W-1:0] cur [3] = '{10'h000, 10'h000, 10'h01E};
  logic [`CL_PCT_W-1:0] harm [3] = '{default: 7'h00};
  logic [`CL_CUR_W-1:0] fe_cur [3];
  logic [`CL_PCT_W-1:0] fe_harm [3];
  logic cyc_done;
  logic [`CL_CUR_W-1:0] idle_set = 10'h014;
  logic [`CL_CUR_W-1:0] start_set = 10'h064;
  logic [`CL_TIME_W-1:0] max_set = 15'h0064;
  logic [`CL_PCT_W-1:0] harm_set = 7'h14;
  logic o_cl, o_inr, o_blk;
  logic [2:0] exp_q [$];
  logic [2:0] prev_q = 3'h0;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 I_MCLK = ~I_MCLK;
  cl_front_end cl_front_end_i (.i_mclk(I_MCLK), .i_rst(I_RST),
    .i_cur(cur), .i_harm(harm), .o_cur(fe_cur), .o_harm(fe_harm),
    .o_cycle_done(cyc_done));
  cold_load_detector cold_load_detector_i (.I_MCLK(I_MCLK),
    .I_RST(I_RST), .i_phase_cur_0(fe_cur[0]),
    .i_phase_cur_1(fe_cur[1]), .i_phase_cur_2(fe_cur[2]),
    .i_second_harmonic_ratio_0(fe_harm[0]),
    .i_second_harmonic_ratio_1(fe_harm[1]),
    .i_second_harmonic_ratio_2(fe_harm[2]),
    .i_cycle_done(cyc_done), .i_idle_set(idle_set),
    .i_start_set(start_set), .i_max_time_set(max_set),
    .i_harm_set(harm_set), .o_cold_load(o_cl), .o_inrush(o_inr),
    .o_inrush_block(o_blk));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [2:0] e, input logic [2:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Phase currents change just after an edge
  task automatic drive(input logic [9:0] a, b, c, input int n);
    @(posedge I_MCLK);
    cur[0] <= a;
    cur[1] <= b;
    cur[2] <= c;
    repeat (n) @(posedge I_MCLK);
  endtask
  // Every output change must match the oldest note
  always @(negedge I_MCLK) begin
    if (!I_RST && {o_cl, o_inr, o_blk} !== prev_q) begin
      chk(exp_q.size() > 0 ? exp_q.pop_front() : prev_q,
        {o_cl, o_inr, o_blk});
      prev_q <= {o_cl, o_inr, o_blk};
    end
  end
  // Hang guard, far beyond the few hundred cycles needed
  always @(posedge I_MCLK) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hBD81));
    // Idle kept at or below 25 so test 5 still leaves idle at 25
    idle_set <= 10'(20 + $urandom_range(5));
    // Any legal maximum time outlasts every scenario here
    max_set <= 15'(1 + $urandom_range(29999));
    repeat (4) @(posedge I_MCLK);
    I_RST <= 1'b0;
    // Phase 2 never idle: a rise must stay silent
    drive(10'h0C8, 10'h000, 10'h01E, 20);
    $display("test 1 done");
    // Rise without harmonic: block released after a cycle
    harm <= '{7'($urandom_range(19)), 7'h00, 7'($urandom_range(19))};
    drive(10'h000, 10'h000, 10'h000, 4);
    exp_q.push_back(3'h5);
    exp_q.push_back(3'h4);
    exp_q.push_back(3'h0);
    drive(10'(101 + $urandom_range(800)), 10'h000, 10'h000, 40);
    drive(10'h032, 10'h000, 10'h000, 6);
    chk(3'(exp_q.size()), 3'h0);
    $display("test 2 done");
    // Clamped threshold 99, phase 1 at 100 keeps block
    harm_set <= 7'h7F;
    harm[1] <= 7'h64;
    drive(10'h000, 10'h000, 10'h000, 4);
    exp_q.push_back(3'h7);
    exp_q.push_back(3'h0);
    drive(10'h000, 10'h3E8, 10'h000, 40);
    drive(10'h000, 10'h000, 10'h000, 6);
    chk(3'(exp_q.size()), 3'h0);
    $display("test 3 done");
    // Zero threshold: inrush follows cold load
    harm_set <= 7'h00;
    harm <= '{default: 7'h00};
    drive(10'h000, 10'h000, 10'h000, 4);
    exp_q.push_back(3'h7);
    exp_q.push_back(3'h0);
    drive(10'h000, 10'h000, 10'h0C8, 40);
    drive(10'h000, 10'h000, 10'h000, 6);
    chk(3'(exp_q.size()), 3'h0);
    $display("test 4 done");
    // Start setting 0 clamps to 30: 25 silent, 40 detects
    start_set <= 10'h000;
    harm_set <= 7'h14;
    drive(10'h000, 10'h000, 10'h000, 4);
    drive(10'h019, 10'h000, 10'h000, 10);
    exp_q.push_back(3'h5);
    exp_q.push_back(3'h4);
    exp_q.push_back(3'h0);
    drive(10'h028, 10'h000, 10'h000, 40);
    drive(10'h000, 10'h000, 10'h000, 6);
    chk(3'(exp_q.size()), 3'h0);
    $display("test 5 done");
    summarize();
  end
endmodule
`default_nettype wire
